/* test/ebi_card_nand_pin_mux_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module ebi_card_nand_pin_mux_bench;
  import ebimux_pkg::*;
  logic         clk, rst, access_req, access_rnw, slow_clock_mode, wait_request_n;
  logic         access_done, access_busy, nand_window_hit, cs67_conflict;
  logic [31:0]  access_addr;
  logic [3:0]   access_bytes, stall;
  logic [25:0]  addr_pin;
  ebimux_cfg_s  cfg;
  ebimux_pins_s pins;
  int           fails, num_checks;
  logic [2:0]   md [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
  ebimux_top u_dut (.clk, .rst, .cfg, .access_req, .access_addr, .access_rnw, .slow_clock_mode,
    .access_bytes, .wait_request_n, .access_done, .access_busy, .pins, .addr_pin,
    .nand_window_hit, .cs67_conflict);
  ebimux_mem_model u_mem (.clk, .rst, .pins, .stall, .wait_request_n);
  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Expected {mask, rd, we, io_rd, io_wr}
  function automatic logic [7:0] exp_stb(input logic [31:0] a, input logic rnw, input logic h);
    if (!((a[31:28] == 4'h5 && cfg.card_region4_enable) ||
          (a[31:28] == 4'h6 && cfg.card_region5_enable))) return {4'hc, h ? 4'hf : rnw ? 4'h7 : 4'hb};
    if (a[23:22] == 2'h3) return {4'hf, h ? 4'h7 : rnw ? 4'h5 : 4'h6};
    if (a[23:21] == 3'h4) return {4'hf, h ? 4'hf : rnw ? 4'hd : 4'he};
    return {4'hf, h ? 4'hf : rnw ? 4'h7 : 4'hb};
  endfunction
  function automatic logic [7:0] exp_cs(input logic [31:0] a, input logic rnw, input logic p);
    logic [7:0] v;
    v = ~(8'h01 << (a[31:28] - 4'h1));
    if (p && cfg.nand_region_enable && a[31:28] == 4'h4) v[rnw ? 6 : 7] = 1'b0;
    return v;
  endfunction
  // One access, timed and compared at pulse and hold
  task automatic run(input logic [31:0] a, input logic rnw, input logic slow, input logic [3:0] st);
    logic [7:0] e;
    int         n;
    @(posedge clk);
    access_req <= 1'b1;
    access_addr <= a;
    access_rnw <= rnw;
    slow_clock_mode <= slow;
    stall <= st;
    access_bytes <= 4'($urandom);
    @(posedge clk);
    access_req <= 1'b0;
    for (n = 1; n < 40; n++) begin
      @(posedge clk);
      #1;
      e = exp_stb(a, rnw, access_done);
      if (n == 1 || access_done === 1'b1) begin
        chk("strobes", e[3:0] & e[7:4], {pins.rd_pin_n, pins.we_pin_n, pins.b1_pin_n, pins.b3_pin_n} & e[7:4]);
        chk("cs pins", exp_cs(a, rnw, n == 1), pins.cs_pin_n);
      end
      if (access_done === 1'b1) break;
    end
    chk("length", (slow ? 10 : 4) + st, n + 1);
    chk("addr pins", a[25:0], addr_pin);
    chk("nand hit", cfg.nand_region_enable && a[31:28] == 4'h4, nand_window_hit);
    chk("cs67 conflict", cfg.nand_region_enable && (a[31:28] == 4'h7 || a[31:28] == 4'h8),
        cs67_conflict);
    if (e[7:4] == 4'hf) chk("direction", rnw, pins.a25_pin);
    if (n == 40) final_report();
  endtask
  // Main sequence
  initial begin
    ebimux_cfg_s c;
    logic [3:0]  t;
    void'($urandom(32'h4eb7));
    {rst, access_req, access_rnw, slow_clock_mode} = 4'h8;
    {access_addr, access_bytes, stall, cfg} = '0;
    {fails, num_checks} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset pins", {8'hff, 5'h1e}, pins);
    @(posedge clk);
    cfg <= 3'h6;
    for (int m = 0; m < 20; m++) run({4'h5 + 4'(m[0]), 4'h0, md[m / 4], 21'h15}, m[1], 1'b0, 4'h0);
    @(posedge clk);
    cfg <= 3'h1;
    run(32'h5000_0010, 1'b1, 1'b0, 4'h0);
    run(32'h4040_0000, 1'b0, 1'b0, 4'h2);
    run(32'h4020_0000, 1'b1, 1'b1, 4'h3);
    @(posedge clk);
    cfg <= 3'h0;
    run(32'h7000_0004, 1'b0, 1'b0, 4'h1);
    run(32'h8000_0008, 1'b1, 1'b1, 4'h0);
    repeat (60) begin
      c = 3'($urandom);
      t = 4'h1 + 4'($urandom % 8);
      if (c.nand_region_enable && t > 4'h6) t = 4'h4;
      @(posedge clk);
      cfg <= c;
      run({t, 28'($urandom)}, 1'($urandom), ($urandom % 6) == 0, 4'($urandom % 4));
    end
    final_report();
  end
endmodule
`default_nettype wire

/* test/ebimux_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module ebimux_chk (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire ebimux_pkg::ebimux_cfg_s  cfg,
  input wire logic                     access_req,
  input wire logic [31:0]              access_addr,
  input wire logic                     access_rnw,
  input wire logic                     slow_clock_mode,
  input wire logic                     wait_request_n,
  input wire logic                     access_done,
  input wire logic                     access_busy,
  input wire ebimux_pkg::ebimux_pins_s pins,
  input wire logic                     nand_window_hit
);
  import ebimux_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [3:0] top;
  logic       card;
  logic       nand_acc;
  // Decode of the access in flight
  assign top  = access_addr[31:28];
  assign card = access_busy && ((top == 4'h5 && cfg.card_region4_enable) ||
                                (top == 4'h6 && cfg.card_region5_enable));
  assign nand_acc = access_busy && cfg.nand_region_enable && top == 4'h4;
  sequence s_take;
    access_req && !access_busy;
  endsequence
  sequence s_fast;
    (s_take and !slow_clock_mode) ##1 wait_request_n [*4];
  endsequence
  sequence s_slow;
    (s_take and slow_clock_mode) ##1 wait_request_n [*8] ##1 wait_request_n [*2];
  endsequence
  AST_FAST_LEN: assert property (s_fast |-> access_done)
    else $error("fast access did not finish on time");
  AST_SLOW_LEN: assert property (s_slow |-> access_done)
    else $error("slow access did not finish on time");
  AST_SLOW_MIN: assert property ((s_take and slow_clock_mode) |=> !access_done [*8])
    else $error("slow access finished early");
  AST_WAIT_HOLD: assert property (access_busy && !access_done && !wait_request_n |=> access_busy)
    else $error("access ended while wait was low");
  AST_IDLE_PINS: assert property (!access_busy |-> pins.cs_pin_n == 8'hff && pins.rd_pin_n && pins.we_pin_n)
    else $error("strobe active while idle");
  AST_CS_PIN: assert property (access_busy && !nand_acc && top != 4'h0 &&
    (top < 4'h7 || (top == 4'h7 || top == 4'h8) && !cfg.nand_region_enable)
    |-> pins.cs_pin_n == ~(8'h01 << (top - 4'h1))) else $error("wrong chip select pin");
  AST_CARD_RNW: assert property (card |-> pins.a25_pin == access_rnw)
    else $error("card direction not held");
  AST_IO_MODE: assert property (card && access_addr[23:21] == 3'h4 |-> pins.rd_pin_n && pins.we_pin_n)
    else $error("memory pair active in io mode");
  AST_IDE_MODE: assert property (card && access_addr[23:22] == 2'h3 |-> !pins.rd_pin_n)
    else $error("output enable not held in ide mode");
  AST_NAND_RD: assert property (nand_acc && access_rnw |-> pins.cs_pin_n[6] == pins.rd_pin_n)
    else $error("nand read strobe wrong");
  AST_NAND_HIT: assert property (nand_window_hit == nand_acc)
    else $error("nand window flag wrong");
endmodule
bind ebimux_top ebimux_chk u_chk (.clk, .rst, .cfg, .access_req, .access_addr, .access_rnw,
  .slow_clock_mode, .wait_request_n, .access_done, .access_busy, .pins, .nand_window_hit);
`default_nettype wire

/* test/ebimux_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ebimux_mem_model (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire ebimux_pkg::ebimux_pins_s pins,
  input wire logic [3:0]               stall,
  output logic                         wait_request_n
);
  import ebimux_pkg::*;
  logic [3:0] cnt_ff;
  logic       sel_ff;
  // Stretch each access by stall cycles once a select falls
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      sel_ff <= 1'b0;
    end else begin
      sel_ff <= ~&pins.cs_pin_n;
      if (~&pins.cs_pin_n && !sel_ff) begin
        cnt_ff <= stall;
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
  assign wait_request_n = (cnt_ff == 4'h0); // Low-active wait
endmodule
`default_nettype wire

/* verilog/ebimux_pkg.sv */
package ebimux_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned EBIMUX_NUM_CS     = 8;
  localparam int unsigned EBIMUX_ADDR_W     = 26;
  localparam int unsigned EBIMUX_DATA_W     = 32;
  localparam int unsigned EBIMUX_PAGE_BYTES = 32;

  // ----------------------------------------------------------------
  // Address windows (system address, top nibble)
  // ----------------------------------------------------------------
  localparam logic [31:0] EBIMUX_NAND_BASE = 32'h4000_0000;
  localparam logic [31:0] EBIMUX_NAND_LAST = 32'h4fff_ffff;
  localparam logic [31:0] EBIMUX_CS67_BASE = 32'h7000_0000;
  localparam logic [31:0] EBIMUX_CS67_LAST = 32'h8fff_ffff;

  // ----------------------------------------------------------------
  // Chip select indices
  // ----------------------------------------------------------------
  localparam int unsigned EBIMUX_CS_NAND  = 3;
  localparam int unsigned EBIMUX_CS_CARD0 = 4;
  localparam int unsigned EBIMUX_CS_CARD1 = 5;
  localparam int unsigned EBIMUX_CS_SIX   = 6;
  localparam int unsigned EBIMUX_CS_SEVEN = 7;

  // ----------------------------------------------------------------
  // Card mode field: address bits 23..21
  // ----------------------------------------------------------------
  localparam int unsigned EBIMUX_MODE_LSB = 21;
  localparam logic [2:0]  EBIMUX_MODE_ATTR    = 3'h0;
  localparam logic [2:0]  EBIMUX_MODE_COMMON  = 3'h2;
  localparam logic [2:0]  EBIMUX_MODE_IO      = 3'h4;
  localparam logic [2:0]  EBIMUX_MODE_IDE     = 3'h6;
  localparam logic [2:0]  EBIMUX_MODE_ALT_IDE = 3'h7;

  // Decoded card mode, one-hot
  typedef enum logic [4:0] {
    EBIMUX_CM_ATTR    = 5'h01,
    EBIMUX_CM_COMMON  = 5'h02,
    EBIMUX_CM_IO      = 5'h04,
    EBIMUX_CM_IDE     = 5'h08,
    EBIMUX_CM_OTHER   = 5'h10
  } ebimux_cmode_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Raw strobes from the static memory controller (all active low)
  typedef struct packed {
    logic [7:0]  chip_select_n;
    logic        read_strobe_n;
    logic        write_enable_n;
    logic        byte1_write_n;
    logic        byte3_write_n;
    logic [25:0] addr;
    logic        rnw;
  } ebimux_smc_s;

  // Shared and dedicated pins toward the outside
  typedef struct packed {
    logic [7:0] cs_pin_n;
    logic       rd_pin_n;
    logic       we_pin_n;
    logic       b1_pin_n;
    logic       b3_pin_n;
    logic       a25_pin;
  } ebimux_pins_s;

  // Region enables (chip-select assignment)
  typedef struct packed {
    logic card_region4_enable;
    logic card_region5_enable;
    logic nand_region_enable;
  } ebimux_cfg_s;

endpackage

/* verilog/ebimux_top.sv */
`timescale 1ns/10ps
`default_nettype none

module ebimux_top
  import ebimux_pkg::*;
#(
  parameter int unsigned ADDR_W = ebimux_pkg::EBIMUX_ADDR_W,
  parameter int unsigned DATA_W = ebimux_pkg::EBIMUX_DATA_W
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire ebimux_pkg::ebimux_cfg_s cfg,
  input  wire logic                   access_req,
  input  wire logic [31:0]            access_addr,
  input  wire logic                   access_rnw,
  input  wire logic                   slow_clock_mode,
  input  wire logic [3:0]             access_bytes,
  input  wire logic                   wait_request_n,
  output logic                        access_done,
  output logic                        access_busy,
  output ebimux_pkg::ebimux_pins_s    pins,
  output logic [ADDR_W-1:0]           addr_pin,
  output logic                        nand_window_hit,
  output logic                        cs67_conflict
);
  import ebimux_pkg::*;

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam logic [3:0] SETUP_CYC      = 4'h1;
  localparam logic [3:0] PULSE_CYC      = 4'h2;
  localparam logic [3:0] HOLD_CYC       = 4'h1;
  localparam logic [3:0] SLOW_PULSE_CYC = 4'h8;
  localparam logic [4:0] PAGE_LAST      = 5'h1f;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Chip select index from the top nibble of the system address
  function automatic logic [2:0] cs_index(input logic [31:0] a);
    logic [3:0] n;
    n = a[31:28];
    cs_index = 3'(n - 4'h1);
  endfunction

  // Card mode from address bits 23..21
  function automatic ebimux_cmode_e card_mode(input logic [25:0] a);
    logic [2:0] f;
    f = a[EBIMUX_MODE_LSB+2:EBIMUX_MODE_LSB];
    unique case (f)
      EBIMUX_MODE_ATTR:    card_mode = EBIMUX_CM_ATTR;
      EBIMUX_MODE_COMMON:  card_mode = EBIMUX_CM_COMMON;
      EBIMUX_MODE_IO:      card_mode = EBIMUX_CM_IO;
      EBIMUX_MODE_IDE,
      EBIMUX_MODE_ALT_IDE: card_mode = EBIMUX_CM_IDE;
      default:             card_mode = EBIMUX_CM_OTHER;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Access sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SETUP = 4'h2,
    ST_PULSE = 4'h4,
    ST_HOLD  = 4'h8
  } ebimux_state_e;

  ebimux_state_e state_ff;
  logic [3:0]    cnt_ff;
  logic [31:0]   addr_ff;
  logic          rnw_ff;
  logic [3:0]    bytes_ff;
  logic [4:0]    page_ff;
  logic          slow_ff;
  logic [2:0]    csi;
  logic          nand_hit;
  ebimux_smc_s   static_mem_ctrl;
  ebimux_cmode_e cmode;
  logic          card_acc;
  logic          card_io;
  logic [3:0]    pulse_len;

  assign csi       = cs_index(addr_ff);
  assign pulse_len = slow_ff ? SLOW_PULSE_CYC : PULSE_CYC;

  // ----------------------------------------------------------------
  // Sequencer: setup, pulse (stretched by wait), hold
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 4'h0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (access_req) begin
            state_ff <= ST_SETUP;
            cnt_ff   <= SETUP_CYC;
          end
        end
        ST_SETUP: begin
          if (cnt_ff <= 4'h1) begin
            state_ff <= ST_PULSE;
            cnt_ff   <= pulse_len;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_PULSE: begin
          if (!wait_request_n) begin
            cnt_ff <= cnt_ff;
          end else if (cnt_ff <= 4'h1) begin
            state_ff <= ST_HOLD;
            cnt_ff   <= HOLD_CYC;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_HOLD: begin
          if (cnt_ff <= 4'h1) begin
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
      endcase
    end
  end

  // Address, direction and byte lanes latched for the whole access
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_ff  <= 32'h0;
      rnw_ff   <= 1'b1;
      bytes_ff <= 4'h0;
      slow_ff  <= 1'b0;
    end else if (state_ff == ST_IDLE && access_req) begin
      addr_ff  <= access_addr;
      rnw_ff   <= access_rnw;
      bytes_ff <= access_bytes;
      slow_ff  <= slow_clock_mode;
    end
  end

  // Page counter: burst reads within one 32-byte page
  always_ff @(posedge clk) begin
    if (rst) begin
      page_ff <= 5'h0;
    end else if (state_ff == ST_IDLE && access_req) begin
      if (access_rnw && access_addr[31:5] == addr_ff[31:5] && page_ff != PAGE_LAST) begin
        page_ff <= page_ff + 5'h1;
      end else begin
        page_ff <= 5'h0;
      end
    end
  end

  assign access_busy = (state_ff != ST_IDLE);
  assign access_done = (state_ff == ST_HOLD) && (cnt_ff <= 4'h1);

  // ----------------------------------------------------------------
  // Raw controller strobes
  // ----------------------------------------------------------------
  always_comb begin
    static_mem_ctrl                = '1;
    static_mem_ctrl.addr           = addr_ff[25:0];
    static_mem_ctrl.rnw            = rnw_ff;
    if (state_ff != ST_IDLE) begin
      static_mem_ctrl.chip_select_n[csi] = 1'b0;
    end
    if (state_ff == ST_PULSE) begin
      static_mem_ctrl.read_strobe_n  = !rnw_ff ? 1'b1 : 1'b0;
      static_mem_ctrl.write_enable_n = rnw_ff;
      static_mem_ctrl.byte1_write_n  = rnw_ff | !bytes_ff[1];
      static_mem_ctrl.byte3_write_n  = rnw_ff | !bytes_ff[3];
    end
  end

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  assign nand_hit = (addr_ff >= EBIMUX_NAND_BASE) && (addr_ff <= EBIMUX_NAND_LAST)
                    && access_busy;
  assign nand_window_hit = nand_hit && cfg.nand_region_enable;
  assign cs67_conflict   = cfg.nand_region_enable && access_busy &&
                           (addr_ff >= EBIMUX_CS67_BASE) && (addr_ff <= EBIMUX_CS67_LAST);

  assign cmode    = card_mode(static_mem_ctrl.addr);
  assign card_acc = (cfg.card_region4_enable && !static_mem_ctrl.chip_select_n[EBIMUX_CS_CARD0]) ||
                    (cfg.card_region5_enable && !static_mem_ctrl.chip_select_n[EBIMUX_CS_CARD1]);
  assign card_io  = (cmode == EBIMUX_CM_IO) || (cmode == EBIMUX_CM_IDE);

  // ----------------------------------------------------------------
  // Pin multiplexer, purely combinational
  // ----------------------------------------------------------------
  always_comb begin
    pins          = '1;
    pins.cs_pin_n = static_mem_ctrl.chip_select_n;
    // Card selects follow their chip select edge for edge
    pins.cs_pin_n[EBIMUX_CS_CARD0] = static_mem_ctrl.chip_select_n[EBIMUX_CS_CARD0];
    pins.cs_pin_n[EBIMUX_CS_CARD1] = static_mem_ctrl.chip_select_n[EBIMUX_CS_CARD1];
    // NAND strobes take the chip select 6 and 7 pins
    if (cfg.nand_region_enable) begin
      pins.cs_pin_n[EBIMUX_CS_SIX]   = !(nand_hit && !static_mem_ctrl.chip_select_n[EBIMUX_CS_NAND])
                                       | static_mem_ctrl.read_strobe_n;
      pins.cs_pin_n[EBIMUX_CS_SEVEN] = !(nand_hit && !static_mem_ctrl.chip_select_n[EBIMUX_CS_NAND])
                                       | static_mem_ctrl.write_enable_n;
    end
    if (card_acc) begin
      // Output/write enable for memory modes, I/O pair for I/O and IDE
      pins.rd_pin_n = card_io ? (cmode == EBIMUX_CM_IDE ? 1'b0 : 1'b1)
                              : static_mem_ctrl.read_strobe_n;
      pins.we_pin_n = card_io ? 1'b1 : static_mem_ctrl.write_enable_n;
      pins.b1_pin_n = card_io ? static_mem_ctrl.read_strobe_n : 1'b1;
      pins.b3_pin_n = card_io ? static_mem_ctrl.write_enable_n : 1'b1;
      pins.a25_pin  = static_mem_ctrl.rnw;
    end else begin
      pins.rd_pin_n = static_mem_ctrl.read_strobe_n;
      pins.we_pin_n = static_mem_ctrl.write_enable_n;
      pins.b1_pin_n = static_mem_ctrl.byte1_write_n;
      pins.b3_pin_n = static_mem_ctrl.byte3_write_n;
      pins.a25_pin  = static_mem_ctrl.addr[25];
    end
  end

  // Address bus pins, 26 bits wide
  assign addr_pin = ADDR_W'(static_mem_ctrl.addr);

endmodule

`default_nettype wire
